// *** logic/io_lamp_ctrl.sv ***
// digital i/o lines, fieldbus i/o byte and status lamps
//
// Added by the designer: the address map and the address-and-strobe port.
module io_lamp_ctrl #(
  parameter int BLINK_HALF = io_lamp_pkg::BLINK_HALF_CYC,
  parameter int PULSE_LEN = io_lamp_pkg::PULSE_CYC
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic fb_wr,
  input wire logic [7:0] fb_out_byte,
  output logic [7:0] fb_in_byte,
  input wire logic [1:0] pulse_req,
  input wire logic [1:0] cmp_res,
  output logic switch_out_one,
  output logic switch_out_two,
  output logic [1:0] disp_out,
  input wire logic [2:0] g2_in,
  output logic [2:0] g2_out,
  output logic [2:0] g2_oe,
  output logic [2:0] line_green,
  output logic [2:0] line_red,
  input wire logic [1:0] eth_link,
  input wire logic [1:0] eth_act,
  output logic [1:0] eth_link_lamp,
  output logic [1:0] eth_act_lamp,
  output logic eth_fwd_en,
  input wire logic init_done,
  input wire logic cfg_err,
  input wire logic sys_err,
  input wire logic plc_session,
  output logic ready_lamp,
  output logic fault_lamp,
  output logic fieldbus_link_lamp,
  output logic auto_param_en,
  input wire logic dcp_wr,
  input wire logic [7:0] dcp_station,
  output logic irq
);
  import io_lamp_pkg::*;

  function automatic logic pick_src(input logic [1:0] mode, input logic direct,
                                    input logic pulse, input logic comp);
    case (mode)
      SRC_PULSE: pick_src = pulse;
      SRC_COMP: pick_src = comp;
      default: pick_src = direct;
    endcase
  endfunction

  logic [7:0] ctrl_ff, stn_ff;
  logic [N_OUT-1:0] cmd_ff;
  logic [IRQ_W-1:0] irq_st_ff, irq_msk_ff;
  logic dcp_lock_ff;
  logic [31:0] rdata_ff;
  logic [2:0] in_s1_ff, in_s2_ff, in_prev_ff;
  logic [1:0] lk_s1_ff, lk_s2_ff, lk_prev_ff;
  logic [1:0] ac_s1_ff, ac_s2_ff, ac_prev_ff, act_seen_ff;
  logic [31:0] blink_cnt_ff;
  logic blink_ph_ff;
  logic fault_prev_ff, plc_prev_ff;
  bus_state_t bus_st_ff, nxt_bus_st;
  logic [1:0] logic_out;
  logic [1:0] sw_ff, disp_ff;
  logic [2:0] g2o_ff, g2oe_ff, grn_ff, red_ff;
  logic [1:0] elk_ff, eac_ff;
  logic fwd_ff, rdy_ff, flt_ff, bfl_ff, ape_ff, irq_ff;
  logic [7:0] io_ff;

  // bus decode
  wire wr_ctrl = reg_wr && reg_addr == ADDR_CTRL;
  wire wr_mb = reg_wr && reg_addr == ADDR_MB_OUT;
  wire wr_ist = reg_wr && reg_addr == ADDR_IRQ_ST;
  wire wr_msk = reg_wr && reg_addr == ADDR_IRQ_MSK;
  wire wr_stn = reg_wr && reg_addr == ADDR_STN;
  wire g2_is_out = ctrl_ff[CTL_DIR];
  wire blink_wrap = blink_cnt_ff == 32'(BLINK_HALF - 1);
  wire any_link = |lk_s2_ff;
  wire fault_now = cfg_err || sys_err;
  wire [7:0] io_byte = g2_is_out ? {3'h0, g2o_ff, sw_ff ^ {ctrl_ff[CTL_INV2],
                       ctrl_ff[CTL_INV1]}} : {5'h0, in_s2_ff};

  logic [31:0] rd_mux;
  always_comb begin
    case (reg_addr)
      ADDR_CTRL: rd_mux = {24'h0, ctrl_ff};
      ADDR_MB_OUT: rd_mux = {27'h0, cmd_ff};
      ADDR_IO: rd_mux = {24'h0, io_byte};
      ADDR_STAT: rd_mux = {24'h0, dcp_lock_ff, 1'b0, bus_st_ff, elk_ff, flt_ff, rdy_ff};
      ADDR_IRQ_ST: rd_mux = {28'h0, irq_st_ff};
      ADDR_IRQ_MSK: rd_mux = {28'h0, irq_msk_ff};
      ADDR_STN: rd_mux = {24'h0, stn_ff};
      default: rd_mux = 32'h0;
    endcase
  end

  // events that raise the interrupt
  wire [IRQ_W-1:0] ev;
  assign ev[IRQ_INCHG] = !g2_is_out && (in_s2_ff != in_prev_ff);
  assign ev[IRQ_FAULT] = fault_now && !fault_prev_ff;
  assign ev[IRQ_LINK] = lk_s2_ff != lk_prev_ff;
  assign ev[IRQ_PLC] = plc_session != plc_prev_ff;
  // set wins over a same-cycle write-one clear
  wire [IRQ_W-1:0] nxt_irq_st = (irq_st_ff & ~(wr_ist ? reg_wdata[IRQ_W-1:0] :
                                 {IRQ_W{1'b0}})) | ev;

  // last writer wins; fieldbus beats modbus in a tie
  wire [N_OUT-1:0] nxt_cmd = fb_wr ? fb_out_byte[N_OUT-1:0] :
                             wr_mb ? reg_wdata[N_OUT-1:0] : cmd_ff;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl_ff <= CTRL_RST;
      cmd_ff <= '0;
      irq_st_ff <= '0;
      irq_msk_ff <= '0;
      rdata_ff <= '0;
      stn_ff <= 8'h00;
      dcp_lock_ff <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl_ff <= reg_wdata[7:0];
      cmd_ff <= nxt_cmd;
      irq_st_ff <= nxt_irq_st;
      if (wr_msk) irq_msk_ff <= reg_wdata[IRQ_W-1:0];
      rdata_ff <= reg_rd ? rd_mux : 32'h0;
      // discovery assignment locks out local writes
      if (dcp_wr) begin
        stn_ff <= dcp_station;
        dcp_lock_ff <= 1'b1;
      end else if (wr_stn && !dcp_lock_ff) begin
        stn_ff <= reg_wdata[7:0];
      end
    end
  end

  // group-2, link and activity pin inputs pass two flops first
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      in_s1_ff <= '0;
      in_s2_ff <= '0;
      lk_s1_ff <= '0;
      lk_s2_ff <= '0;
      ac_s1_ff <= '0;
      ac_s2_ff <= '0;
    end else begin
      in_s1_ff <= g2_in;
      in_s2_ff <= in_s1_ff;
      lk_s1_ff <= eth_link;
      lk_s2_ff <= lk_s1_ff;
      ac_s1_ff <= eth_act;
      ac_s2_ff <= ac_s1_ff;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      in_prev_ff <= '0;
      lk_prev_ff <= '0;
      ac_prev_ff <= '0;
      fault_prev_ff <= 1'b0;
      plc_prev_ff <= 1'b0;
      blink_cnt_ff <= '0;
      blink_ph_ff <= 1'b0;
    end else begin
      in_prev_ff <= in_s2_ff;
      lk_prev_ff <= lk_s2_ff;
      ac_prev_ff <= ac_s2_ff;
      fault_prev_ff <= fault_now;
      plc_prev_ff <= plc_session;
      blink_cnt_ff <= blink_wrap ? 32'h0 : blink_cnt_ff + 32'h1;
      if (blink_wrap) blink_ph_ff <= !blink_ph_ff;
    end
  end

  // group-1 channels: source select plus pulse stretch
  genvar gi;
  generate
    for (gi = 0; gi < N_G1; gi++) begin : g_grp1
      logic [31:0] pcnt_ff;
      wire [1:0] mode = ctrl_ff[CTL_MODE1 + 2*gi +: 2];
      wire pulse_on = pcnt_ff != 32'h0;
      always_ff @(posedge ref_clk) begin
        if (srst) pcnt_ff <= '0;
        else if (pulse_req[gi]) pcnt_ff <= 32'(PULSE_LEN);
        else if (pulse_on) pcnt_ff <= pcnt_ff - 32'h1;
      end
      assign logic_out[gi] = pick_src(mode, cmd_ff[gi], pulse_on, cmp_res[gi]);
    end
  endgenerate

  // activity holds until the end of a lit blink phase (blink_ph_ff high)
  generate
    for (gi = 0; gi < 2; gi++) begin : g_eth
      always_ff @(posedge ref_clk) begin
        if (srst) act_seen_ff[gi] <= 1'b0;
        else if (ac_s2_ff[gi] && !ac_prev_ff[gi]) act_seen_ff[gi] <= 1'b1;
        else if (blink_wrap && blink_ph_ff) act_seen_ff[gi] <= 1'b0;
      end
    end
  endgenerate

  // fieldbus lamp state machine
  always_comb begin
    case (bus_st_ff)
      BUS_NOLINK: nxt_bus_st = any_link ? BUS_LINKED : BUS_NOLINK;
      BUS_LINKED: nxt_bus_st = !any_link ? BUS_NOLINK :
                               plc_session ? BUS_ACTIVE : BUS_LINKED;
      BUS_ACTIVE: nxt_bus_st = !any_link ? BUS_NOLINK :
                               !plc_session ? BUS_LINKED : BUS_ACTIVE;
      default: nxt_bus_st = BUS_NOLINK;
    endcase
  end

  wire [2:0] g2_cmd = cmd_ff[4:2];
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      bus_st_ff <= BUS_NOLINK;
      sw_ff <= '0;
      disp_ff <= '0;
      g2o_ff <= '0;
      g2oe_ff <= '0;
      grn_ff <= '0;
      red_ff <= '0;
      elk_ff <= '0;
      eac_ff <= '0;
      fwd_ff <= 1'b0;
      rdy_ff <= 1'b0;
      flt_ff <= 1'b0;
      bfl_ff <= 1'b0;
      ape_ff <= 1'b0;
      irq_ff <= 1'b0;
      io_ff <= '0;
    end else begin
      bus_st_ff <= nxt_bus_st;
      sw_ff <= logic_out ^ {ctrl_ff[CTL_INV2], ctrl_ff[CTL_INV1]};
      disp_ff <= logic_out;
      g2o_ff <= g2_is_out ? g2_cmd : 3'h0;
      g2oe_ff <= {3{g2_is_out}};
      grn_ff <= g2_is_out ? 3'h0 : in_s2_ff;
      red_ff <= g2_is_out ? g2_cmd : 3'h0;
      elk_ff <= lk_s2_ff;
      eac_ff <= act_seen_ff & {2{blink_ph_ff}};
      fwd_ff <= &lk_s2_ff;
      rdy_ff <= init_done || blink_ph_ff;
      flt_ff <= fault_now;
      bfl_ff <= nxt_bus_st == BUS_NOLINK ||
                (nxt_bus_st == BUS_LINKED && blink_ph_ff);
      ape_ff <= !ctrl_ff[CTL_NOAUTO];
      irq_ff <= |(nxt_irq_st & irq_msk_ff);
      io_ff <= io_byte;
    end
  end

  assign reg_rdata = rdata_ff;
  assign fb_in_byte = io_ff;
  assign switch_out_one = sw_ff[0];
  assign switch_out_two = sw_ff[1];
  assign disp_out = disp_ff;
  assign g2_out = g2o_ff;
  assign g2_oe = g2oe_ff;
  assign line_green = grn_ff;
  assign line_red = red_ff;
  assign eth_link_lamp = elk_ff;
  assign eth_act_lamp = eac_ff;
  assign eth_fwd_en = fwd_ff;
  assign ready_lamp = rdy_ff;
  assign fault_lamp = flt_ff;
  assign fieldbus_link_lamp = bfl_ff;
  assign auto_param_en = ape_ff;
  assign irq = irq_ff;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  sequence fb_write_s;
    fb_wr;
  endsequence
  sequence out_mode_s;
    g2_is_out [*2];
  endsequence

  dir_shared_a: assert property (g2_oe == '0 || g2_oe == 3'h7)
    else $error("group-2 enables differ");
  in_byte_a: assert property (!g2_is_out [*3] |=> fb_in_byte == {5'h0, $past(in_s2_ff)})
    else $error("input byte wrong");
  // the byte is taken at the strobe edge, three edges before the check
  fb_cmd_a: assert property (fb_write_s ##1 out_mode_s |-> ##1
    g2_out == $past(fb_out_byte[4:2], 3))
    else $error("fieldbus command not applied");
  mb_cmd_a: assert property (wr_mb && !fb_wr |=> cmd_ff == $past(reg_wdata[4:0]))
    else $error("modbus command not taken");
  disp_inv_a: assert property (switch_out_one == (disp_out[0] ^ $past(ctrl_ff[CTL_INV1])))
    else $error("indicator follows inverted state");
  red_lamp_a: assert property (g2_is_out && g2_cmd[0] |=> line_red[0])
    else $error("output lamp not red");
  green_lamp_a: assert property (!g2_is_out && in_s2_ff[1] |=> line_green[1])
    else $error("input lamp not green");
  fault_lamp_a: assert property ($rose(cfg_err) |=> fault_lamp)
    else $error("fault lamp missed error");
  ready_on_a: assert property (init_done [*2] |-> ready_lamp)
    else $error("ready lamp not steady");
  bus_off_a: assert property (bus_st_ff == BUS_ACTIVE && $past(bus_st_ff) == BUS_ACTIVE
    |-> !fieldbus_link_lamp)
    else $error("bus lamp lit when connected");
  link_lamp_a: assert property (lk_s2_ff[0] |=> eth_link_lamp[0])
    else $error("link lamp not lit");
  irq_a: assert property (ev[IRQ_FAULT] && irq_msk_ff[IRQ_FAULT] |=> irq ##1 irq_st_ff[IRQ_FAULT])
    else $error("interrupt not raised");

  // a pulse shows on the indicator two edges after its request
  sequence pulse_start_s;
    pulse_req[0] && ctrl_ff[CTL_MODE1 +: 2] == SRC_PULSE;
  endsequence
  pulse_out_a: assert property (pulse_start_s |=> ##1 disp_out[0])
    else $error("pulse output not started");
  g2_quiet_a: assert property (!g2_is_out |=> g2_out == 3'h0)
    else $error("group-2 drives in input mode");
  dir_out_a: assert property (g2_is_out |=> g2_oe == 3'h7)
    else $error("group-2 enables not all set");
  fwd_en_a: assert property (&lk_s2_ff |=> eth_fwd_en)
    else $error("pass-through not enabled");
  // the implication skips the reset value seen at the first edge
  auto_param_a: assert property (!ctrl_ff[CTL_NOAUTO] |=> auto_param_en)
    else $error("automatic parameterisation off");
  act_dark_a: assert property (!blink_ph_ff |=> eth_act_lamp == 2'h0)
    else $error("activity lamp lit in off phase");
  ready_blink_a: assert property (!init_done && !blink_ph_ff |=> !ready_lamp)
    else $error("ready lamp steady during init");
  bus_nolink_a: assert property (!any_link |=> fieldbus_link_lamp)
    else $error("bus lamp dark without link");
  stn_lock_a: assert property (dcp_lock_ff && !dcp_wr |=> stn_ff == $past(stn_ff))
    else $error("station changed after discovery");
  fault_sys_a: assert property (sys_err |=> fault_lamp)
    else $error("fault lamp missed system error");
  inv_pin_a: assert property (switch_out_two == (disp_out[1] ^ $past(ctrl_ff[CTL_INV2])))
    else $error("second indicator follows inverted state");
  line_excl_a: assert property ((line_green & line_red) == 3'h0)
    else $error("line lamp both colours");
  link_dark_a: assert property (!lk_s2_ff[1] |=> !eth_link_lamp[1])
    else $error("link lamp lit without link");
  // in a tie the fieldbus byte is kept
  mb_fb_tie_a: assert property (fb_wr && wr_mb |=> cmd_ff == $past(fb_out_byte[4:0]))
    else $error("tie not won by fieldbus");
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
endmodule

// *** logic/io_lamp_pkg.sv ***
// constants and types shared by the digital i/o and status lamp block
package io_lamp_pkg;
  localparam int CLK_NS = 100;
  localparam int BLINK_HALF_NS = 250000000;
  localparam int BLINK_HALF_CYC = BLINK_HALF_NS / CLK_NS;
  localparam int PULSE_NS = 50000000;
  localparam int PULSE_CYC = PULSE_NS / CLK_NS;
  localparam int N_G1 = 2;
  localparam int N_G2 = 3;
  localparam int N_OUT = 5;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MB_OUT = 8'h04;
  localparam logic [7:0] ADDR_IO = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_ST = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MSK = 8'h14;
  localparam logic [7:0] ADDR_STN = 8'h18;
  localparam int CTL_DIR = 0;
  localparam int CTL_INV1 = 1;
  localparam int CTL_INV2 = 2;
  localparam int CTL_MODE1 = 3;
  localparam int CTL_MODE2 = 5;
  localparam int CTL_NOAUTO = 7;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam int IRQ_INCHG = 0;
  localparam int IRQ_FAULT = 1;
  localparam int IRQ_LINK = 2;
  localparam int IRQ_PLC = 3;
  localparam int IRQ_W = 4;
  typedef enum logic [1:0] {
    SRC_DIRECT = 2'b00,
    SRC_PULSE = 2'b01,
    SRC_COMP = 2'b10
  } g1_src_t;
  typedef enum logic [1:0] {
    BUS_NOLINK = 2'b00,
    BUS_LINKED = 2'b01,
    BUS_ACTIVE = 2'b10
  } bus_state_t;
endpackage

// *** tb/plc_model.sv ***
// fieldbus controller model: writes the output byte, reads back the i/o byte
module plc_model (
  input wire logic ref_clk,
  input wire logic [7:0] fb_in_byte,
  output logic fb_wr,
  output logic [7:0] fb_out_byte,
  output logic [7:0] seen_byte
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    fb_wr = 1'b0;
    fb_out_byte = 8'h00;
    seen_byte = 8'h00;
  end
  always @(posedge ref_clk) begin
    seen_byte <= fb_in_byte;
  end
  // byte is inverted once the strobe ends so stale data never passes for a command
  task automatic send(input logic [7:0] b);
    @(posedge ref_clk);
    fb_wr <= 1'b1;
    fb_out_byte <= b;
    @(posedge ref_clk);
    fb_wr <= 1'b0;
    fb_out_byte <= ~b;
  endtask
endmodule

// *** tb/tb_digital_io_and_status_lamps.sv ***
// self-checking bench for the digital i/o and status lamp block
module tb_digital_io_and_status_lamps;
  import io_lamp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk, srst, reg_wr, reg_rd, fb_wr, switch_out_one, switch_out_two, eth_fwd_en;
  logic init_done, cfg_err, sys_err, plc_session, ready_lamp, fault_lamp;
  logic fieldbus_link_lamp, auto_param_en, dcp_wr, irq;
  logic [7:0] reg_addr, fb_out_byte, fb_in_byte, dcp_station;
  logic [31:0] reg_wdata, reg_rdata;
  logic [1:0] pulse_req, cmp_res, disp_out, eth_link, eth_act, eth_link_lamp, eth_act_lamp;
  logic [2:0] g2_in, g2_out, g2_oe, line_green, line_red;
  int err_total = 0;
  int check_count = 0;
  int n_rdy, n_bus, n_act;
  logic traffic = 1'b0;

  // traffic toggles the second port's activity pin every cycle
  always @(posedge ref_clk) begin
    eth_act <= {traffic & ~eth_act[1], 1'b0};
  end

  io_lamp_ctrl #(.BLINK_HALF(4), .PULSE_LEN(3)) u_io_lamp_ctrl (.*);
  plc_model u_plc_model (.ref_clk(ref_clk), .fb_in_byte(fb_in_byte), .fb_wr(fb_wr),
    .fb_out_byte(fb_out_byte), .seen_byte());

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // let n edges pass, then look where outputs have settled
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    chk(reg_rdata, exp);
  endtask

  // 16 cycles span two whole blink periods, so a blinking lamp is lit for exactly 8
  task automatic window;
    n_rdy = 0;
    n_bus = 0;
    n_act = 0;
    repeat (16) begin
      @(negedge ref_clk);
      n_rdy += int'(ready_lamp === 1'b1);
      n_bus += int'(fieldbus_link_lamp === 1'b1);
      n_act += int'(eth_act_lamp[1] === 1'b1);
    end
  endtask

  task automatic t_reset;
    rdchk(ADDR_CTRL, {24'h0, CTRL_RST});
    rdchk(8'hFC, 32'h0);
    chk(irq, 1'b0);
    chk(auto_param_en, 1'b1);
  endtask

  task automatic t_out_mode;
    wr(ADDR_CTRL, 32'h01);
    u_plc_model.send(8'h1F);
    tick(4);
    chk(g2_oe, 3'h7);
    chk(g2_out, 3'h7);
    chk(line_red, 3'h7);
    chk({switch_out_two, switch_out_one}, 2'h3);
    chk(fb_in_byte, 8'h1F);
    u_plc_model.send(8'h15);
    tick(4);
    chk(fb_in_byte, 8'h15);
    chk(line_red, 3'h5);
    wr(ADDR_MB_OUT, 32'h0A);
    tick(4);
    chk({g2_out, switch_out_two, switch_out_one}, 5'h0A);
    rdchk(ADDR_IO, 32'h0A);
    wr(ADDR_CTRL, 32'h07);
    u_plc_model.send(8'h01);
    tick(4);
    chk({switch_out_two, switch_out_one}, 2'h2);
    chk(disp_out, 2'h1);
    chk(fb_in_byte, 8'h01);
  endtask

  task automatic t_in_mode;
    wr(ADDR_CTRL, 32'h00);
    wr(ADDR_IRQ_MSK, 32'h01);
    g2_in <= 3'h5;
    tick(6);
    chk(g2_oe, 3'h0);
    chk(g2_out, 3'h0);
    chk(fb_in_byte, 8'h05);
    chk(line_green, 3'h5);
    chk(line_red, 3'h0);
    chk(irq, 1'b1);
    rdchk(ADDR_IRQ_ST, 32'h1);
    wr(ADDR_IRQ_ST, 32'h1);
    tick(2);
    chk(irq, 1'b0);
    wr(ADDR_IRQ_MSK, 32'h0);
    g2_in <= 3'h0;
    tick(6);
    chk(irq, 1'b0);
    wr(ADDR_IRQ_ST, 32'hF);
  endtask

  task automatic t_pulse;
    int n;
    n = 0;
    wr(ADDR_CTRL, 32'h48);
    cmp_res <= 2'h2;
    @(posedge ref_clk);
    pulse_req <= 2'h1;
    @(posedge ref_clk);
    pulse_req <= 2'h0;
    repeat (20) begin
      @(negedge ref_clk);
      n += int'(switch_out_one === 1'b1);
    end
    chk(n, 3);
    chk(switch_out_two, 1'b1);
  endtask

  task automatic t_lamps;
    tick(2);
    chk(fieldbus_link_lamp, 1'b1);
    chk(eth_link_lamp, 2'h0);
    eth_link <= 2'h3;
    traffic <= 1'b1;
    tick(12);
    chk(eth_link_lamp, 2'h3);
    chk(eth_fwd_en, 1'b1);
    window;
    chk(n_rdy, 8);
    chk(n_bus, 8);
    chk(n_act, 8);
    init_done <= 1'b1;
    plc_session <= 1'b1;
    tick(4);
    window;
    chk(n_rdy, 16);
    chk(n_bus, 0);
    wr(ADDR_IRQ_MSK, 32'h2);
    cfg_err <= 1'b1;
    tick(3);
    chk(fault_lamp, 1'b1);
    chk(irq, 1'b1);
    cfg_err <= 1'b0;
    sys_err <= 1'b1;
    tick(3);
    chk(fault_lamp, 1'b1);
    sys_err <= 1'b0;
    tick(3);
    chk(fault_lamp, 1'b0);
    wr(ADDR_CTRL, 32'h80);
    tick(2);
    chk(auto_param_en, 1'b0);
  endtask

  task automatic t_station;
    @(posedge ref_clk);
    dcp_station <= 8'h2A;
    dcp_wr <= 1'b1;
    @(posedge ref_clk);
    dcp_wr <= 1'b0;
    wr(ADDR_STN, 32'h55);
    rdchk(ADDR_STN, 32'h2A);
  endtask

  initial begin
    srst = 1'b1;
    {reg_wr, reg_rd, init_done, cfg_err, sys_err, plc_session, dcp_wr} = 7'h00;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    dcp_station = 8'h00;
    {pulse_req, cmp_res, eth_link} = 6'h00;
    g2_in = 3'h0;
    repeat (10) @(posedge ref_clk);
    srst <= 1'b0;
    tick(3);
    t_reset;
    t_out_mode;
    t_in_mode;
    t_pulse;
    t_lamps;
    t_station;
    wrap_up;
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    wrap_up;
  end
endmodule
